// ---- bench/dsp_peer.sv ----
// dsp_peer: far side of the pads (encoder, spi peer, current sensors)
// assumes the bench sets the levels the peer drives on undriven pads
`timescale 1ns/10ps
module dsp_peer (
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe_n,
    input wire logic [2:0] lvl,
    input wire logic [2:0] cs_pad_out,
    input wire logic [2:0] cs_pad_oe_n,
    input wire logic [2:0] cs_lvl,
    output logic [2:0] pad_in,
    output logic [2:0] cs_pad_in
);
    // peer yields wherever the device drives, so no contention
    // lvl[2] is the peer's slave select level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad_in[i] = pad_oe_n[i] ? lvl[i] : pad_out[i];
            cs_pad_in[i] = cs_pad_oe_n[i] ? cs_lvl[i] : cs_pad_out[i];
        end
    end
endmodule

// ---- bench/dsp_pin_share_props.sv ----
// dsp_pin_share_props: port-level checks for the pin sharing block
// assumes the single mclk domain and synchronous active-high rst
`timescale 1ns/10ps
module dsp_pin_share_props (
    input wire logic mclk,
    input wire logic rst,
    input wire logic phase_b_alt_select,
    input wire logic select_a,
    input wire logic [2:0] timer_sel,
    input wire logic [2:0] gpio_sel,
    input wire logic [15:0] port_c_pullup_reg,
    input wire logic pullup_we,
    input wire logic [2:0] pad_in,
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe_n,
    input wire logic [2:0] pad_pullup,
    input wire logic [2:0] cs_pad_pullup,
    input wire logic dec1_phase_b_in,
    input wire logic spi_master,
    input wire logic spi_enable,
    input wire logic spi_mosi_out,
    input wire logic spi_miso_out,
    input wire logic spi_one_slave_select,
    input wire logic spi_selected,
    input wire logic spi_mode_fault
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    property p_pu;
        logic [15:0] v;
        (pullup_we, v = port_c_pullup_reg) |=>
            pad_pullup == v[3:1] && cs_pad_pullup == v[10:8];
    endproperty
    pu_write_a: assert property (p_pu)
        else $error("pull-up word not applied");
    pu_hold_a: assert property (!pullup_we |=> $stable(pad_pullup) &&
        $stable(cs_pad_pullup)) else $error("pull-up changed unwritten");
    mosi_drive_a: assert property ($past(phase_b_alt_select) &&
        spi_master && spi_enable |-> !pad_oe_n[0] &&
        pad_out[0] == spi_mosi_out) else $error("master-out not driven");
    miso_float_a: assert property ($past(select_a) && !spi_selected
        |-> pad_oe_n[1]) else $error("unselected slave drives");
    miso_drive_a: assert property ($past(select_a) && spi_selected
        |-> !pad_oe_n[1] && pad_out[1] == spi_miso_out)
        else $error("selected slave not driving");
    ss_use_a: assert property (spi_selected == (spi_enable &&
        !spi_master && !spi_one_slave_select) && spi_mode_fault ==
        (spi_enable && spi_master && !spi_one_slave_select))
        else $error("slave select misused");
    dec_route_a: assert property ((!phase_b_alt_select &&
        !timer_sel[0] && !gpio_sel[0] && $stable(pad_in[0]))[*6] |->
        dec1_phase_b_in == pad_in[0]) else $error("decoder not routed");
    dec_idle_a: assert property (phase_b_alt_select[*2] |->
        dec1_phase_b_in == 1'b0) else $error("idle decoder input");
    cover property (spi_selected);
    cover property (spi_mode_fault);
    cover property (pullup_we ##1 pad_pullup == 3'h0);
endmodule

// ---- bench/dsp_pin_share_tb.sv ----
// dsp_pin_share_tb: directed scenarios for the pin sharing block
// assumes dsp_pkg, the design and the peer model are compiled first
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
    $display("BAD %0t %h %h", $time, a, e); end end
module dsp_pin_share_tb;
    logic mclk = 1'b0, rst = 1'b1, pullup_we = 1'b0, select_b = 1'b0;
    logic phase_b_alt_select = 1'b0, select_a = 1'b0, spi_master = 1'b0;
    logic spi_enable = 1'b0, spi_mosi_out = 1'b0, spi_miso_out = 1'b0;
    logic [2:0] timer_sel = 3'h0, gpio_sel = 3'h0, cs_gpio_sel = 3'h0;
    logic [2:0] gpio_dir = 3'h0, gpio_dout = 3'h0, cs_gpio_dir = 3'h0;
    logic [2:0] cs_gpio_dout = 3'h0, timer_out = 3'h0, timer_oe = 3'h0;
    logic [2:0] lvl = 3'h5, cs_lvl = 3'h6;
    logic [15:0] port_c_pullup_reg = 16'h0000;
    logic [2:0] pad_in, pad_out, pad_oe_n, pad_pullup, cs_pad_in;
    logic [2:0] cs_pad_out, cs_pad_oe_n, cs_pad_pullup, cs_gpio_din;
    logic dec1_phase_b_in, dec1_index_in, dec1_home_in, spi_selected;
    logic spi_one_slave_select, spi_mode_fault, port_c_line_two;
    logic current_status_a_zero, current_status_a_one, current_status_a_two;
    logic timer_b_chan_one, timer_b_chan_two, timer_b_chan_three;
    logic spi_one_master_out, spi_one_master_in;
    logic port_c_line_one, port_c_line_three;
    int err_count = 0, n_tests = 0;
    always #2.5 mclk = ~mclk;
    dsp_pin_share i_dut (.*);
    dsp_peer i_peer (.*);
    // settle past the synchroniser and agreement stage
    task wt(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task t_reset;
        `CHK(pad_oe_n, 3'h7)
        `CHK({pad_pullup, cs_pad_pullup}, 6'h3f)
        for (int i = 0; i < 2; i++) begin
            `CHK(dec1_phase_b_in, lvl[0])
            `CHK(dec1_index_in, lvl[1])
            `CHK(dec1_home_in, lvl[2])
            `CHK({current_status_a_two, current_status_a_one,
                current_status_a_zero}, cs_lvl)
            @(posedge mclk);
            lvl <= 3'h2;
            cs_lvl <= 3'h1;
            wt(6);
        end
    endtask
    task t_pullup;
        @(posedge mclk);
        port_c_pullup_reg <= 16'hf8f1;
        pullup_we <= 1'b1;
        @(posedge mclk);
        port_c_pullup_reg <= 16'h0404;
        wt(1);
        `CHK({pad_pullup, cs_pad_pullup}, 6'h14)
        @(posedge mclk);
        pullup_we <= 1'b0;
        port_c_pullup_reg <= 16'hffff;
        wt(2);
        `CHK({pad_pullup, cs_pad_pullup}, 6'h14)
    endtask
    task t_slave;
        @(posedge mclk);
        {select_a, select_b, spi_enable, spi_miso_out} <= 4'hf;
        lvl <= 3'h0;
        wt(6);
        `CHK(spi_one_slave_select, 1'b0)
        `CHK(spi_selected, 1'b1)
        `CHK({pad_oe_n[1], pad_out[1]}, 2'h1)
        `CHK(spi_one_master_in, 1'b1)
        @(posedge mclk);
        lvl <= 3'h4;
        wt(6);
        `CHK({spi_selected, pad_oe_n[1]}, 2'h1)
        @(posedge mclk);
        {select_a, spi_enable} <= 2'h0;
    endtask
    task t_master;
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk);
            {phase_b_alt_select, spi_master, spi_enable} <= 3'h7;
            lvl <= 3'h0;
            spi_mosi_out <= i[0];
            wt(6);
            `CHK({pad_oe_n[0], pad_out[0]}, {1'b0, i[0]})
            `CHK(spi_one_master_out, i[0])
            `CHK({spi_mode_fault, dec1_phase_b_in}, 2'h2)
        end
        @(posedge mclk);
        {phase_b_alt_select, spi_master, spi_enable, select_b} <= 4'h0;
    endtask
    task t_gpio;
        @(posedge mclk);
        {gpio_sel, gpio_dir, gpio_dout} <= 9'h1e9;
        {cs_gpio_sel, cs_gpio_dir, cs_gpio_dout} <= 9'h049;
        lvl <= 3'h2;
        cs_lvl <= 3'h6;
        wt(6);
        `CHK({pad_oe_n, pad_out[2], pad_out[0]}, 5'h9)
        `CHK({cs_pad_oe_n, port_c_line_two}, 4'hd)
        `CHK({port_c_line_one, port_c_line_three}, 2'h2)
        `CHK({cs_gpio_din, current_status_a_two}, 4'h3)
        `CHK(current_status_a_one, 1'b1)
        `CHK({current_status_a_zero, dec1_index_in}, 2'h0)
    endtask
    // timer function: pin 1 left undriven so the peer level shows through
    task t_timer;
        @(posedge mclk);
        {gpio_sel, timer_sel, timer_oe, timer_out} <= 12'h1e9;
        wt(6);
        `CHK({pad_oe_n, pad_out}, 6'h11)
        `CHK({timer_b_chan_two, timer_b_chan_one}, 2'h3)
        `CHK({timer_b_chan_three, dec1_home_in}, 2'h0)
    endtask
    task test_done;
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        wt(6);
        t_reset();
        t_pullup();
        t_slave();
        t_master();
        t_gpio();
        t_timer();
        test_done();
    end
endmodule
bind dsp_pin_share dsp_pin_share_props i_props (.*);

// ---- rtl/dsp_pin_share.sv ----
// dsp_pin_share: pin sharing for decoder 1, timer b, spi 1, port c gpio
// and the three current-status inputs of the first pwm module.
// assumes pin pads resolve level from in/out/oe (oe low = driving).
`timescale 1ns/10ps
module dsp_pin_share
(
    input wire logic mclk,
    input wire logic rst,
    // configuration
    input wire logic phase_b_alt_select,
    input wire logic select_a,
    input wire logic select_b,
    input wire logic [2:0] timer_sel,
    input wire logic [2:0] gpio_sel,
    input wire logic [2:0] cs_gpio_sel,
    input wire logic [dsp_pkg::DSP_PUR_W-1:0] port_c_pullup_reg,
    input wire logic pullup_we,
    input wire logic [2:0] gpio_dir,
    input wire logic [2:0] gpio_dout,
    input wire logic [2:0] cs_gpio_dir,
    input wire logic [2:0] cs_gpio_dout,
    // shared pads: phase b, index, home
    input wire logic [2:0] pad_in,
    output logic [2:0] pad_out,
    output logic [2:0] pad_oe_n,
    output logic [2:0] pad_pullup,
    // current-status pads
    input wire logic [2:0] cs_pad_in,
    output logic [2:0] cs_pad_out,
    output logic [2:0] cs_pad_oe_n,
    output logic [2:0] cs_pad_pullup,
    // decoder 1
    output logic dec1_phase_b_in,
    output logic dec1_index_in,
    output logic dec1_home_in,
    // timer b channels 1..3
    input wire logic [2:0] timer_out,
    input wire logic [2:0] timer_oe,
    output logic timer_b_chan_one,
    output logic timer_b_chan_two,
    output logic timer_b_chan_three,
    // spi 1
    input wire logic spi_master,
    input wire logic spi_mosi_out,
    input wire logic spi_miso_out,
    input wire logic spi_enable,
    output logic spi_one_master_out,
    output logic spi_one_master_in,
    output logic spi_one_slave_select,
    output logic spi_selected,
    output logic spi_mode_fault,
    // gpio readback
    output logic port_c_line_one,
    output logic port_c_line_two,
    output logic port_c_line_three,
    output logic [2:0] cs_gpio_din,
    // first pwm module current status
    output logic current_status_a_zero,
    output logic current_status_a_one,
    output logic current_status_a_two
);
    import dsp_pkg::*;

    dsp_func_t func_r [DSP_NPIN];
    logic [2:0] sel_spi;
    logic [2:0] pin_s;
    logic [2:0] cs_s;
    logic [2:0] pup_r;
    logic [2:0] cs_pup_r;
    logic [2:0] cs_gpio_r;

    // spi wins over gpio, gpio over timer; decoder is the fallback
    function automatic dsp_func_t pick(input logic spi, input logic gp,
                                       input logic tm);
        if (spi) begin
            pick = DSP_FN_SPI;
        end else if (gp) begin
            pick = DSP_FN_GPIO;
        end else if (tm) begin
            pick = DSP_FN_TMR;
        end else begin
            pick = DSP_FN_DEC;
        end
    endfunction

    assign sel_spi = {select_b, select_a, phase_b_alt_select};

    // registered select so each pin changes function on one clean edge
    always_ff @(posedge mclk) begin
        for (int i = 0; i < DSP_NPIN; i++) begin
            if (rst) begin
                func_r[i] <= DSP_FN_DEC;
            end else begin
                func_r[i] <= pick(sel_spi[i], gpio_sel[i], timer_sel[i]);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cs_gpio_r <= 3'h0;
        end else begin
            cs_gpio_r <= cs_gpio_sel;
        end
    end

    // pull-ups stay on until software writes a cleared bit
    always_ff @(posedge mclk) begin
        if (rst) begin
            pup_r <= DSP_PUR_RST[DSP_PUR_HOME_BIT:DSP_PUR_PHB_BIT];
            cs_pup_r <= DSP_PUR_RST[DSP_PUR_CS2_BIT:DSP_PUR_CS0_BIT];
        end else if (pullup_we) begin
            pup_r <= {port_c_pullup_reg[DSP_PUR_HOME_BIT],
                      port_c_pullup_reg[DSP_PUR_IDX_BIT],
                      port_c_pullup_reg[DSP_PUR_PHB_BIT]};
            cs_pup_r <= {port_c_pullup_reg[DSP_PUR_CS2_BIT],
                         port_c_pullup_reg[DSP_PUR_CS1_BIT],
                         port_c_pullup_reg[DSP_PUR_CS0_BIT]};
        end
    end
    assign pad_pullup = pup_r;
    assign cs_pad_pullup = cs_pup_r;

    // pads are off-chip: synchronise before use
    for (genvar g = 0; g < 3; g++) begin : g_sync
        dsp_sync #(.RST_VAL(1'b1)) u_pin (
            .mclk(mclk),
            .rst(rst),
            .din(pad_in[g]),
            .dout(pin_s[g])
        );
        dsp_sync #(.RST_VAL(1'b1)) u_cs (
            .mclk(mclk),
            .rst(rst),
            .din(cs_pad_in[g]),
            .dout(cs_s[g])
        );
    end

    // unselected functions see a fixed idle level
    function automatic logic route_in(input dsp_func_t f,
                                      input dsp_func_t want,
                                      input logic lvl, input logic idle);
        route_in = (f == want) ? lvl : idle;
    endfunction

    always_comb begin
        dec1_phase_b_in = route_in(func_r[DSP_PIN_PHB], DSP_FN_DEC,
                                   pin_s[DSP_PIN_PHB], 1'b0);
        dec1_index_in = route_in(func_r[DSP_PIN_IDX], DSP_FN_DEC,
                                 pin_s[DSP_PIN_IDX], 1'b0);
        dec1_home_in = route_in(func_r[DSP_PIN_HOME], DSP_FN_DEC,
                                pin_s[DSP_PIN_HOME], 1'b0);
        timer_b_chan_one = route_in(func_r[DSP_PIN_PHB], DSP_FN_TMR,
                                    pin_s[DSP_PIN_PHB], 1'b0);
        timer_b_chan_two = route_in(func_r[DSP_PIN_IDX], DSP_FN_TMR,
                                    pin_s[DSP_PIN_IDX], 1'b0);
        timer_b_chan_three = route_in(func_r[DSP_PIN_HOME], DSP_FN_TMR,
                                      pin_s[DSP_PIN_HOME], 1'b0);
        port_c_line_one = route_in(func_r[DSP_PIN_PHB], DSP_FN_GPIO,
                                   pin_s[DSP_PIN_PHB], 1'b0);
        port_c_line_two = route_in(func_r[DSP_PIN_IDX], DSP_FN_GPIO,
                                   pin_s[DSP_PIN_IDX], 1'b0);
        port_c_line_three = route_in(func_r[DSP_PIN_HOME], DSP_FN_GPIO,
                                     pin_s[DSP_PIN_HOME], 1'b0);
        spi_one_master_out = route_in(func_r[DSP_PIN_PHB], DSP_FN_SPI,
                                      pin_s[DSP_PIN_PHB], 1'b0);
        spi_one_master_in = route_in(func_r[DSP_PIN_IDX], DSP_FN_SPI,
                                     pin_s[DSP_PIN_IDX], 1'b0);
        spi_one_slave_select = route_in(func_r[DSP_PIN_HOME], DSP_FN_SPI,
                                        pin_s[DSP_PIN_HOME],
                                        DSP_SS_IDLE);
    end

    // slave select: selection in slave mode, arbitration in master mode
    assign spi_selected = spi_enable && !spi_master &&
                          !spi_one_slave_select;
    assign spi_mode_fault = spi_enable && spi_master &&
                            !spi_one_slave_select;

    // output side; the spi engine places each bit a half serial clock
    // ahead of the sampling edge, this block adds no delay to that path
    always_comb begin
        for (int i = 0; i < DSP_NPIN; i++) begin
            pad_out[i] = 1'b0;
            pad_oe_n[i] = 1'b1;
            case (func_r[i])
                DSP_FN_TMR: begin
                    pad_out[i] = timer_out[i];
                    pad_oe_n[i] = !timer_oe[i];
                end
                DSP_FN_GPIO: begin
                    pad_out[i] = gpio_dout[i];
                    pad_oe_n[i] = !gpio_dir[i];
                end
                DSP_FN_SPI: begin
                    if (i == DSP_PIN_PHB) begin
                        pad_out[i] = spi_mosi_out;
                        pad_oe_n[i] = !(spi_enable && spi_master);
                    end else if (i == DSP_PIN_IDX) begin
                        pad_out[i] = spi_miso_out;
                        // float unless selected as slave
                        pad_oe_n[i] = !spi_selected;
                    end
                end
                default: begin
                    pad_out[i] = 1'b0;
                end
            endcase
        end
    end

    // current-status pins: pwm input by default, gpio when selected
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            cs_pad_out[i] = cs_gpio_dout[i];
            cs_pad_oe_n[i] = !(cs_gpio_r[i] && cs_gpio_dir[i]);
            cs_gpio_din[i] = cs_gpio_r[i] ? cs_s[i] : 1'b0;
        end
        current_status_a_zero = cs_gpio_r[0] ? 1'b0 : cs_s[0];
        current_status_a_one = cs_gpio_r[1] ? 1'b0 : cs_s[1];
        current_status_a_two = cs_gpio_r[2] ? 1'b0 : cs_s[2];
    end
endmodule

// ---- rtl/dsp_pkg.sv ----
// dsp_pkg: constants for the decoder/spi/timer/gpio pin sharing block
// assumes one system clock, synchronous active-high reset
package dsp_pkg;
    // per-pin function selects
    typedef enum logic [1:0] {
        DSP_FN_DEC,
        DSP_FN_TMR,
        DSP_FN_SPI,
        DSP_FN_GPIO
    } dsp_func_t;

    // shared decoder pins index 0..2: phase b, index, home
    localparam int DSP_NPIN = 3;
    localparam int DSP_PIN_PHB = 0;
    localparam int DSP_PIN_IDX = 1;
    localparam int DSP_PIN_HOME = 2;
    // port c pull-up bit positions
    localparam int DSP_PUR_PHB_BIT = 1;
    localparam int DSP_PUR_IDX_BIT = 2;
    localparam int DSP_PUR_HOME_BIT = 3;
    localparam int DSP_PUR_CS0_BIT = 8;
    localparam int DSP_PUR_CS1_BIT = 9;
    localparam int DSP_PUR_CS2_BIT = 10;
    localparam int DSP_PUR_W = 16;
    localparam logic [15:0] DSP_PUR_RST = 16'hffff;
    localparam logic [2:0] DSP_IDLE_IN = 3'h0;
    // slave select is active low, so its idle level is high
    localparam logic DSP_SS_IDLE = 1'b1;
endpackage

// ---- rtl/dsp_sync.sv ----
// dsp_sync: three-stage synchroniser with second/third stage agreement
// assumes the input is asynchronous to mclk
`timescale 1ns/10ps
module dsp_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic din,
    output logic dout
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // output moves only when the two settled stages agree
    always_ff @(posedge mclk) begin
        if (rst) begin
            dout <= RST_VAL;
        end else if (s2_r == s3_r) begin
            dout <= s3_r;
        end
    end
endmodule
